/* File: pkg/hsp_pkg.sv */
// Shared constants and types for the high-side on-state fault protection logic
package hsp_pkg;

   // Channel count and timer width
   localparam int unsigned CH_COUNT = 4;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned STAT_W   = 2 * CH_COUNT;

   // Core clock period, in ns
   localparam int unsigned CLK_PERIOD_NS = 50;

   // Default deglitch and retry counts, in core clock cycles
   localparam logic [CNT_W-1:0] OC_CYCLES_DEF    = 16'h0010;
   localparam logic [CNT_W-1:0] STG_CYCLES_DEF   = 16'h0004;
   localparam logic [CNT_W-1:0] RETRY_CYCLES_DEF = 16'h0800;

   // Unit values for counters and limits
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;

   // Two-bit fault codes per channel
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_OC   = 2'h1;
   localparam logic [1:0] FAULT_STG  = 2'h3;

   // Reset values of the fault flag and gate outputs and of the chip select history register
   localparam logic FLT_N_RST = 1'b1;
   localparam logic CS_N_RST  = 1'b1;
   localparam logic GATE_RST  = 1'b0;

   // Per-channel drive state
   typedef enum logic [1:0] {
      CH_IDLE    = 2'b00,
      CH_DRIVE   = 2'b01,
      CH_LATCHED = 2'b10,
      CH_RETRY   = 2'b11
   } hsp_ch_state_type;

   // Shared retry timer state
   typedef enum logic [0:0] {
      RT_IDLE = 1'b0,
      RT_RUN  = 1'b1
   } hsp_rt_state_type;

endpackage

/* File: logic/hsp_deglitch.sv */
// Per-channel on-state deglitch timer with over-current and short-to-ground limits
`timescale 1ns/1ns
module hsp_deglitch (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // Timer control
   input  wire logic                     run,
   input  wire logic                     short_active,
   input  wire logic [hsp_pkg::CNT_W-1:0] oc_limit,
   input  wire logic [hsp_pkg::CNT_W-1:0] stg_limit,
   // Expiry, combinational from the count register
   output logic                          hit
);

   logic [hsp_pkg::CNT_W-1:0] count_reg;
   logic [hsp_pkg::CNT_W-1:0] count_next;
   logic [hsp_pkg::CNT_W-1:0] limit;
   logic [hsp_pkg::CNT_W:0]   count_plus;

   // Limit selection and expiry; a zero limit acts as one cycle
   always_comb begin
      limit = short_active ? stg_limit : oc_limit;
      if (limit == hsp_pkg::CNT_ZERO) begin
         limit = hsp_pkg::CNT_ONE;
      end
      count_plus = {1'b0, count_reg} + {1'b0, hsp_pkg::CNT_ONE};
      // Compare with >= so a short seen after the stg time fires at once
      hit = run && (count_plus >= {1'b0, limit});
      count_next = hsp_pkg::CNT_ZERO;
      if (run) begin
         count_next = (count_reg == hsp_pkg::CNT_MAX) ? count_reg : count_plus[hsp_pkg::CNT_W-1:0];
      end
   end

   // Count register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= hsp_pkg::CNT_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end

endmodule

/* File: logic/hsp_retry_timer.sv */
// Single auto-retry timer shared by all channels
`timescale 1ns/1ns
module hsp_retry_timer (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // Control
   input  wire logic                     start,
   input  wire logic [hsp_pkg::CNT_W-1:0] retry_cycles,
   // Status
   output logic                          busy,
   output logic                          done
);

   hsp_pkg::hsp_rt_state_type state_reg;
   hsp_pkg::hsp_rt_state_type state_next;
   logic [hsp_pkg::CNT_W-1:0] count_reg;
   logic [hsp_pkg::CNT_W-1:0] count_next;
   logic                      done_reg;
   logic                      done_next;
   logic [hsp_pkg::CNT_W:0]   count_plus;

   // A start while running is ignored: the first faulting channel sets the pace
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      done_next  = 1'b0;
      count_plus = {1'b0, count_reg} + {1'b0, hsp_pkg::CNT_ONE};
      case (state_reg)
         hsp_pkg::RT_IDLE: begin
            if (start) begin
               state_next = hsp_pkg::RT_RUN;
               // Start edge counts as the first delay cycle, so the gate stays off exactly the delay
               count_next = hsp_pkg::CNT_ONE;
            end
         end
         hsp_pkg::RT_RUN: begin
            count_next = count_plus[hsp_pkg::CNT_W-1:0];
            if (count_plus >= {1'b0, retry_cycles}) begin
               state_next = hsp_pkg::RT_IDLE;
               done_next  = 1'b1;
            end
         end
         default: begin
            state_next = hsp_pkg::RT_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= hsp_pkg::RT_IDLE;
         count_reg <= hsp_pkg::CNT_ZERO;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         done_reg  <= done_next;
      end
   end

   assign busy = (state_reg == hsp_pkg::RT_RUN);
   assign done = done_reg;

endmodule

/* File: logic/hsp_protect.sv */
// Four-channel high-side on-state over-current and short-to-ground protection
`timescale 1ns/1ns
module hsp_protect (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // Channel commands
   input  wire logic [hsp_pkg::CH_COUNT-1:0]  parallel_channel_input,
   input  wire logic [hsp_pkg::CH_COUNT-1:0]  serial_control_in,
   input  wire logic                          auto_retry_enable,
   input  wire logic                          cs_n,
   // Analog comparator results
   input  wire logic [hsp_pkg::CH_COUNT-1:0]  overcurrent_detect,
   input  wire logic [hsp_pkg::CH_COUNT-1:0]  short_ground_detect,
   // Timing configuration, in core clock cycles
   input  wire logic [hsp_pkg::CNT_W-1:0]     overcurrent_deglitch_cycles,
   input  wire logic [hsp_pkg::CNT_W-1:0]     short_ground_deglitch_cycles,
   input  wire logic [hsp_pkg::CNT_W-1:0]     retry_delay_cycles,
   // Gate and threshold control
   output logic      [hsp_pkg::CH_COUNT-1:0]  gate_drive_out,
   output logic      [hsp_pkg::CH_COUNT-1:0]  threshold_restart,
   // Fault reporting
   output logic                               fault_interrupt_n,
   output logic      [hsp_pkg::STAT_W-1:0]    fault_status
);

   // Cross-channel signals
   logic [hsp_pkg::CH_COUNT-1:0] ch_hit;
   logic [hsp_pkg::CH_COUNT-1:0] ch_retry_req;
   logic                         retry_start;
   logic                         retry_busy;
   logic                         retry_done;
   logic                         cs_prev_reg;
   logic                         cs_prev_next;
   logic                         cs_fall;
   logic                         flt_n_reg;
   logic                         flt_n_next;

   // Chip select edge detect; cs_n is taken as synchronous to core_clk
   always_comb begin
      cs_prev_next = cs_n;
      cs_fall      = cs_prev_reg && !cs_n;
   end

   // Fault interrupt: any new fault wins over a clear in the same cycle
   always_comb begin
      flt_n_next = flt_n_reg;
      if (cs_fall) begin
         flt_n_next = 1'b1;
      end
      if (|ch_hit) begin
         flt_n_next = 1'b0;
      end
   end

   // Global registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_prev_reg <= hsp_pkg::CS_N_RST;
         flt_n_reg   <= hsp_pkg::FLT_N_RST;
      end else begin
         cs_prev_reg <= cs_prev_next;
         flt_n_reg   <= flt_n_next;
      end
   end

   assign fault_interrupt_n = flt_n_reg;

   // Start the shared timer on any fault under retry; ignored while it runs
   assign retry_start = |ch_retry_req;

   hsp_retry_timer u_retry (
      .core_clk     (core_clk),
      .rst          (rst),
      .start        (retry_start),
      .retry_cycles (retry_delay_cycles),
      .busy         (retry_busy),
      .done         (retry_done)
   );

   // Per-channel command, gate state, deglitch and status
   for (genvar ch = 0; ch < hsp_pkg::CH_COUNT; ch++) begin : g_ch
      hsp_pkg::hsp_ch_state_type state_reg;
      hsp_pkg::hsp_ch_state_type state_next;
      logic                      cmd_on;
      logic                      cmd_prev_reg;
      logic                      gate_reg;
      logic                      gate_next;
      logic                      restart_reg;
      logic                      restart_next;
      logic [1:0]                stat_reg;
      logic [1:0]                stat_next;
      logic                      run;
      logic                      short_active;
      logic                      hit;

      // Command is on when either source asks for it
      assign cmd_on = parallel_channel_input[ch] || serial_control_in[ch];

      // Timer runs only while the gate is driven and over-current is seen
      assign run          = gate_reg && overcurrent_detect[ch];
      // Short only counts while driving; it shortens the limit, never starts the timer
      assign short_active = gate_reg && short_ground_detect[ch];

      hsp_deglitch u_deglitch (
         .core_clk     (core_clk),
         .rst          (rst),
         .run          (run),
         .short_active (short_active),
         .oc_limit     (overcurrent_deglitch_cycles),
         .stg_limit    (short_ground_deglitch_cycles),
         .hit          (hit)
      );

      assign ch_hit[ch]       = hit;
      assign ch_retry_req[ch] = hit && auto_retry_enable && !retry_busy;

      // Drive state machine
      always_comb begin
         state_next = state_reg;
         case (state_reg)
            hsp_pkg::CH_IDLE: begin
               if (cmd_on) begin
                  state_next = hsp_pkg::CH_DRIVE;
               end
            end
            hsp_pkg::CH_DRIVE: begin
               if (!cmd_on) begin
                  state_next = hsp_pkg::CH_IDLE;
               end else if (hit && auto_retry_enable) begin
                  state_next = hsp_pkg::CH_RETRY;
               end else if (hit) begin
                  state_next = hsp_pkg::CH_LATCHED;
               end
            end
            hsp_pkg::CH_LATCHED: begin
               // Only an off command frees it; turning on again re-tests the load
               if (!cmd_on) begin
                  state_next = hsp_pkg::CH_IDLE;
               end
            end
            hsp_pkg::CH_RETRY: begin
               if (!cmd_on) begin
                  state_next = hsp_pkg::CH_IDLE;
               end else if (retry_done) begin
                  // Gate back on for one deglitch window: low duty while the fault stays
                  state_next = hsp_pkg::CH_DRIVE;
               end
            end
            default: begin
               state_next = hsp_pkg::CH_IDLE;
            end
         endcase
      end

      // Gate, threshold restart pulse and fault code
      always_comb begin
         gate_next    = (state_next == hsp_pkg::CH_DRIVE);
         restart_next = cmd_on && !cmd_prev_reg;
         stat_next    = stat_reg;
         if (cs_fall) begin
            stat_next = hsp_pkg::FAULT_NONE;
         end
         if (hit) begin
            stat_next = short_active ? hsp_pkg::FAULT_STG : hsp_pkg::FAULT_OC;
         end
      end

      // Channel registers
      always_ff @(posedge core_clk) begin
         if (rst) begin
            state_reg    <= hsp_pkg::CH_IDLE;
            cmd_prev_reg <= 1'b0;
            gate_reg     <= hsp_pkg::GATE_RST;
            restart_reg  <= 1'b0;
            stat_reg     <= hsp_pkg::FAULT_NONE;
         end else begin
            state_reg    <= state_next;
            cmd_prev_reg <= cmd_on;
            gate_reg     <= gate_next;
            restart_reg  <= restart_next;
            stat_reg     <= stat_next;
         end
      end

      assign gate_drive_out[ch]        = gate_reg;
      assign threshold_restart[ch]     = restart_reg;
      assign fault_status[2*ch+1:2*ch] = stat_reg;
   end

endmodule

/* File: sim/hsp_protect_assertions.sv */
// Port-level concurrent checks of the protection block, channel 0 in detail
`timescale 1ns/1ns
module hsp_protect_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Commands, comparators and limits
   input wire logic [3:0]  parallel_channel_input,
   input wire logic [3:0]  serial_control_in,
   input wire logic        auto_retry_enable,
   input wire logic        cs_n,
   input wire logic [3:0]  overcurrent_detect,
   input wire logic [3:0]  short_ground_detect,
   input wire logic [15:0] overcurrent_deglitch_cycles,
   input wire logic [15:0] short_ground_deglitch_cycles,
   // Outputs under check
   input wire logic [3:0]  gate_drive_out,
   input wire logic [3:0]  threshold_restart,
   input wire logic        fault_interrupt_n,
   input wire logic [7:0]  fault_status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Channel 0 shorthands
   wire [3:0] cmd = parallel_channel_input | serial_control_in;
   wire       c0  = cmd[0];
   wire       g0  = gate_drive_out[0];
   wire       oc0 = overcurrent_detect[0];
   wire       s0  = short_ground_detect[0];
   // Consecutive edges with gate and over-current both high; mirrors the deglitch count
   logic [15:0] run_reg;
   logic [15:0] run_next;
   always_comb run_next = (rst | ~(g0 & oc0)) ? 16'h0000 : run_reg + 16'h0001;
   always_ff @(posedge core_clk) run_reg <= run_next;

   property p_off; 1'b1 |=> (gate_drive_out & ~$past(cmd)) == 4'h0; endproperty
   a_off: assert property (p_off) else $error("gate on without command");
   property p_restart; $rose(c0) |=> threshold_restart[0]; endproperty
   a_restart: assert property (p_restart) else $error("no threshold restart");
   property p_quiet; g0 && c0 && !oc0 |=> g0; endproperty
   a_quiet: assert property (p_quiet) else $error("gate dropped without over-current");
   property p_early; g0 && c0 && oc0 && !s0 && run_reg + 16'h0001 < overcurrent_deglitch_cycles |=> g0; endproperty
   a_early: assert property (p_early) else $error("over-current trip too early");
   property p_full; run_reg >= overcurrent_deglitch_cycles |-> !g0; endproperty
   a_full: assert property (p_full) else $error("over-current trip missing");
   property p_short; g0 && c0 && oc0 && s0 && run_reg + 16'h0001 >= short_ground_deglitch_cycles |=> !g0; endproperty
   a_short: assert property (p_short) else $error("short trip missing");
   property p_trip;
      $fell(g0) && $past(c0) |-> !fault_interrupt_n && fault_status[1:0] == ($past(s0) ? 2'h3 : 2'h1);
   endproperty
   a_trip: assert property (p_trip) else $error("trip without flag or code");
   property p_hold; !fault_interrupt_n && !$fell(cs_n) |=> !fault_interrupt_n; endproperty
   a_hold: assert property (p_hold) else $error("flag released without select edge");
   property p_cause; $fell(fault_interrupt_n) |-> fault_status != 8'h00; endproperty
   a_cause: assert property (p_cause) else $error("flag without status");
   property p_latch; $rose(g0) && !auto_retry_enable |-> threshold_restart[0]; endproperty
   a_latch: assert property (p_latch) else $error("gate left latch without command edge");

   // Main scenarios reached
   c_retry: cover property ($fell(g0) && auto_retry_enable);
   c_clear: cover property ($rose(fault_interrupt_n));
   c_short: cover property (fault_status[1:0] == 2'h3);
endmodule

bind hsp_protect hsp_protect_chk u_hsp_protect_chk (.core_clk, .rst, .parallel_channel_input, .serial_control_in,
   .auto_retry_enable, .cs_n, .overcurrent_detect, .short_ground_detect, .overcurrent_deglitch_cycles,
   .short_ground_deglitch_cycles, .gate_drive_out, .threshold_restart, .fault_interrupt_n, .fault_status);

/* File: sim/hsp_host_model.sv */
// Host-side model that pulses chip select to release a latched fault flag
`timescale 1ns/1ns
module hsp_host_model (
   // Clock
   input wire logic core_clk,
   // Clear request from the bench
   input wire logic clr_req,
   // Chip select to the device
   output logic     cs_n
);
   // Changes just after an edge and holds a full cycle, so exactly one clean falling edge is seen
   initial cs_n = 1'b1;
   always @(posedge core_clk) cs_n <= ~clr_req;
endmodule

/* File: sim/hsp_protect_tb.sv */
// Self-checking bench for the high-side protection block
`timescale 1ns/1ns
module hsp_protect_tb;
   // Stimulus and observed signals
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic [3:0]  par      = 4'h0;
   logic [3:0]  ser      = 4'h0;
   logic        ar       = 1'b0;
   logic        clr_req  = 1'b0;
   logic [3:0]  oc       = 4'h0;
   logic [3:0]  sg       = 4'h0;
   logic [15:0] oc_cyc   = 16'h0008;
   logic [15:0] stg_cyc  = 16'h0003;
   logic [15:0] rty_cyc  = 16'h0014;
   logic [15:0] seed     = 16'h004a;
   wire         cs_n;
   wire  [3:0]  gate;
   wire  [3:0]  rstrt;
   wire         flt_n;
   wire  [7:0]  stat;
   int          n_fail      = 0;
   int          check_count = 0;
   int          n;

   always #25 core_clk = ~core_clk;

   hsp_host_model u_hsp_host_model (.core_clk(core_clk), .clr_req(clr_req), .cs_n(cs_n));
   hsp_protect u_hsp_protect (.core_clk(core_clk), .rst(rst), .parallel_channel_input(par), .serial_control_in(ser),
      .auto_retry_enable(ar), .cs_n(cs_n), .overcurrent_detect(oc), .short_ground_detect(sg),
      .overcurrent_deglitch_cycles(oc_cyc), .short_ground_deglitch_cycles(stg_cyc), .retry_delay_cycles(rty_cyc),
      .gate_drive_out(gate), .threshold_restart(rstrt), .fault_interrupt_n(flt_n), .fault_status(stat));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Expected status word for one channel's two-bit code
   function automatic logic [7:0] code(input int ch, input logic [1:0] c);
      return {6'h00, c} << (2 * ch);
   endfunction
   task automatic tick;
      @(negedge core_clk);
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Counts cycles that a gate holds one level; bounded so a stuck gate cannot hang the run
   task automatic run(input int ch, input logic v);
      n = 0;
      while (gate[ch] === v && n < 3000) begin
         n++;
         tick;
      end
      if (n == 3000) begin
         n_fail++;
         summarize;
      end
   endtask
   task automatic clear;
      clr_req = 1'b1;
      tick;
      clr_req = 1'b0;
      tick;
   endtask
   task automatic recmd(input int ch);
      par[ch] = 1'b0;
      tick;
      par[ch] = 1'b1;
      tick;
   endtask
   task automatic done(input string t);
      $display("Test %s finished", t);
   endtask
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20) tick;
      rst = 1'b0;
      tick;
      chk("gate idle", gate, 4'h0);
      chk("status idle", {flt_n, stat}, 16'h0100);
      done("reset");
      // Serial bit alone turns on; a glitch one cycle short of the deglitch is forgiven
      ser[0] = 1'b1;
      tick;
      chk("restart pulse", rstrt, 4'h1);
      oc[0] = 1'b1;
      repeat (7) tick;
      oc[0] = 1'b0;
      tick;
      chk("gate after glitch", gate[0], 1'b1);
      oc[0] = 1'b1;
      run(0, 1'b1);
      chk("oc on-time", 16'(n), oc_cyc);
      chk("oc status", {flt_n, stat}, {8'h00, code(0, 2'h1)});
      done("overcurrent");
      // Latched off until a real off-to-on edge; handing over to the parallel input is no edge
      oc[0] = 1'b0;
      repeat (5) tick;
      chk("latched gate", gate[0], 1'b0);
      clear;
      chk("flag released", {flt_n, stat}, 16'h0100);
      par[0] = 1'b1;
      ser[0] = 1'b0;
      repeat (2) tick;
      chk("still latched", gate[0], 1'b0);
      recmd(0);
      chk("re-armed", {gate[0], rstrt[0]}, 16'h0003);
      done("latch");
      // Short alone never starts the timer; with over-current it trips at the short time
      sg[0] = 1'b1;
      repeat (12) tick;
      chk("short only", gate[0], 1'b1);
      oc[0] = 1'b1;
      run(0, 1'b1);
      chk("short on-time", 16'(n), stg_cyc);
      chk("short status", stat, code(0, 2'h3));
      // Re-arm the shorted channel once only, so the external switch is not cooked
      clear;
      recmd(0);
      run(0, 1'b1);
      chk("shorted at turn-on", 16'(n), stg_cyc);
      clear;
      sg[0] = 1'b0;
      recmd(0);
      repeat (5) tick;
      sg[0] = 1'b1;
      tick;
      chk("late short", {gate[0], flt_n}, 16'h0000);
      done("short");
      // Auto-retry on channel 2: off for the delay, on for the deglitch window
      sg[0] = 1'b0;
      oc[0] = 1'b0;
      par[0] = 1'b0;
      ar = 1'b1;
      clear;
      ser[2] = 1'b1;
      oc[2] = 1'b1;
      tick;
      run(2, 1'b1);
      chk("retry first on", 16'(n), oc_cyc);
      chk("retry status", {flt_n, stat}, {8'h00, code(2, 2'h1)});
      for (int k = 0; k < 2; k++) begin
         run(2, 1'b0);
         chk("retry off-time", 16'(n), rty_cyc);
         run(2, 1'b1);
         chk("retry on-time", 16'(n), oc_cyc);
      end
      oc[2] = 1'b0;
      run(2, 1'b0);
      repeat (30) tick;
      chk("fault gone", gate[2], 1'b1);
      ser[2] = 1'b0;
      tick;
      chk("commanded off", gate[2], 1'b0);
      done("retry");
      // Random traffic in latch mode; the checker judges every edge
      ar = 1'b0;
      for (int k = 0; k < 800; k++) begin
         seed = lfsr(seed);
         if (seed[14:12] == 3'h0)
            par = seed[3:0];
         ser = seed[7:4] & seed[11:8] & seed[3:0];
         oc = seed[11:8] | seed[7:4];
         sg = seed[15:12] & seed[3:0];
         clr_req = seed[5] & seed[9] & seed[1];
         tick;
      end
      {par, ser, oc, sg, clr_req} = 17'h00000;
      repeat (3) tick;
      clear;
      chk("quiet end", {gate, flt_n, stat}, 16'h0100);
      done("random");
      summarize;
   end
endmodule
